// ### verilog/host_bus_port.sv
// Operation
// - Selector picks nonmux, mux or serial style
// - Memory clock is internal clock over four
// - Request dropped within two after DMA write
// - Request dropped within two after DMA read
// - DMA recovery two, plus two if interrupted
// - Serial output valid within three memory clocks
// - First eight clocks shift current register
`timescale 1ns/1ps
`include "hbp_cfg.svh"

module host_bus_port (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// Port style selector
	input wire logic [1:0] PORT_STYLE_SEL_I,
	// Parallel bus pins
	input wire logic CS_N_I,
	input wire logic RD_N_I,
	input wire logic WR_N_I,
	input wire logic ALE_I,
	input wire logic A0_I,
	input wire logic [7:0] AD_I,
	output logic [7:0] AD_O,
	output logic AD_OE_N_O,
	// DMA handshake
	input wire logic DACK_N_I,
	output logic DRQ_O,
	// Serial slave pins
	input wire logic SERIAL_CLK_I,
	input wire logic SERIAL_DI_I,
	output logic SERIAL_DO_O,
	// User read side
	input wire logic DMA_REQ_I,
	input wire logic [7:0] RD_DATA_I,
	output logic RD_TAKEN_O,
	// User write side
	output logic WR_VALID_O,
	output hbp_pkg::host_word_t WR_WORD_O,
	input wire logic WR_READY_I
);

	hbp_pkg::port_state_t st; // Registered state
	hbp_pkg::port_state_t next_st; // Next state
	logic in_ready; // Buffer has room
	logic tick; // One memory-clock period elapsed
	logic sel; // Chip selected (synced)
	logic dack; // DMA acknowledged (synced)
	logic rd_now; // Read strobe active now
	logic rd_was; // Read strobe active last cycle
	logic wr_now; // Write strobe active now
	logic wr_was; // Write strobe active last cycle
	logic parallel; // A parallel style is selected
	logic [2:0] rec_load; // Recovery length for the ending access
	logic [7:0] rx_byte; // Serial byte completed this edge

	// Strobe qualifier: chip select or acknowledge
	function automatic logic strobe_on(input hbp_pkg::pin_t p, input logic is_rd);
		logic s;
		s = is_rd ? ~p.rd_n : ~p.wr_n;
		return s & (~p.cs_n | ~p.dack_n);
	endfunction

	// Decoded views of the synced pins
	always_comb begin
		sel = ~st.s2.cs_n;
		dack = ~st.s2.dack_n;
		// strobe or select, whichever comes last
		rd_now = strobe_on(st.s2, 1'b1);
		rd_was = strobe_on(st.s3, 1'b1);
		wr_now = strobe_on(st.s2, 1'b0);
		wr_was = strobe_on(st.s3, 1'b0);
		parallel = (st.s2.style == `STYLE_NONMUX) || (st.s2.style == `STYLE_MUX);
		rx_byte = {st.shreg[6:0], st.s2.sdi};
		tick = (st.mdiv == `MCLK_CNT_W'(`MCLK_CYC - 1));
		// interrupted DMA gets the extra periods
		if (st.dma_cyc) begin
			rec_load = st.intr ? 3'(`DMA_REC_MCLK + `DMA_EXTRA_MCLK) : 3'(`DMA_REC_MCLK);
		end else begin
			rec_load = 3'(`CPU_REC_MCLK);
		end
	end

	// Next-state logic
	always_comb begin
		next_st = st;
		// two-flop sync, third stage for edges
		next_st.s1 = '{style: PORT_STYLE_SEL_I, cs_n: CS_N_I, rd_n: RD_N_I, wr_n: WR_N_I,
			ale: ALE_I, a0: A0_I, dack_n: DACK_N_I, sclk: SERIAL_CLK_I,
			sdi: SERIAL_DI_I, ad: AD_I};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.mdiv = tick ? '0 : st.mdiv + `MCLK_CNT_W'(1);
		next_st.rd_taken = 1'b0;
		// Hold a word until the buffer takes it
		next_st.push = st.push & ~in_ready;

		// latch the address on the latch enable fall
		if (st.s2.style == `STYLE_MUX && st.s3.ale && !st.s2.ale) begin
			next_st.addr = st.s2.ad[0];
		end

		case (st.phase)
			hbp_pkg::PH_IDLE: begin
				// request only with room and a user need
				next_st.drq = DMA_REQ_I & parallel & in_ready & ~st.push;
				if (parallel && rd_now && !rd_was) begin
					// Read start: drive the bus
					next_st.phase = hbp_pkg::PH_READ;
					next_st.dma_cyc = dack;
					next_st.ad_out = RD_DATA_I;
					next_st.ad_oe_n = 1'b0;
					if (st.s2.style == `STYLE_NONMUX) begin
						next_st.addr = st.s2.a0;
					end
				end else if (parallel && wr_now && !wr_was) begin
					// Write start
					next_st.phase = hbp_pkg::PH_WRITE;
					next_st.dma_cyc = dack;
					if (st.s2.style == `STYLE_NONMUX) begin
						next_st.addr = st.s2.a0;
					end
				end
			end
			hbp_pkg::PH_READ: begin
				if (!rd_now) begin
					// read end: release bus, drop request after DMA
					next_st.ad_oe_n = 1'b1;
					next_st.rd_taken = 1'b1;
					next_st.drq = st.drq & ~st.dma_cyc;
					next_st.intr = st.dma_cyc ? 1'b0 : (st.intr | DMA_REQ_I);
					next_st.rec = rec_load;
					next_st.mdiv = '0;
					next_st.phase = hbp_pkg::PH_RECOVER;
				end
			end
			hbp_pkg::PH_WRITE: begin
				if (!wr_now) begin
					// write end: hand over byte, drop request after DMA
					next_st.push = 1'b1;
					next_st.word = '{dma: st.dma_cyc, addr: st.addr, data: st.s3.ad};
					next_st.drq = st.drq & ~st.dma_cyc;
					next_st.intr = st.dma_cyc ? 1'b0 : (st.intr | DMA_REQ_I);
					next_st.rec = rec_load;
					next_st.mdiv = '0;
					next_st.phase = hbp_pkg::PH_RECOVER;
				end
			end
			hbp_pkg::PH_RECOVER: begin
				if (st.rec != 3'h0) begin
					if (tick) begin
						next_st.rec = st.rec - 3'h1;
					end
				end else if (!st.push) begin
					next_st.phase = hbp_pkg::PH_IDLE;
				end
			end
			default: begin
				next_st.phase = hbp_pkg::PH_IDLE;
			end
		endcase

		// Serial slave: sample on rise, launch on fall
		if (st.s2.style == `STYLE_SERIAL) begin
			if (!sel) begin
				// idle select keeps the register contents
				next_st.bitcnt = 3'h0;
				next_st.sdo = st.shreg[7];
			end else if (st.s2.sclk && !st.s3.sclk) begin
				next_st.shreg = rx_byte;
				next_st.bitcnt = st.bitcnt + 3'h1;
				// group of eight completes a byte
				if (st.bitcnt == 3'(`SER_BITS - 1)) begin
					next_st.push = 1'b1;
					next_st.word = '{dma: 1'b0, addr: 1'b0, data: rx_byte};
					next_st.shreg = RD_DATA_I;
					next_st.rd_taken = 1'b1;
				end
			end else if (!st.s2.sclk && st.s3.sclk) begin
				// output bit a few cycles after the fall
				next_st.sdo = st.shreg[7];
			end
		end
	end

	// State register with synchronous reset
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			st <= '0;
			st.s1 <= '1;
			st.s2 <= '1;
			st.s3 <= '1;
			// Latch enable idles low, so no false fall right after reset
			st.s1.ale <= 1'b0;
			st.s2.ale <= 1'b0;
			st.s3.ale <= 1'b0;
			st.phase <= hbp_pkg::PH_IDLE;
			st.ad_out <= `AD_RST;
			st.ad_oe_n <= 1'b1;
			st.shreg <= `SHREG_RST;
		end else begin
			st <= next_st;
		end
	end

	// Stall-tolerant path toward the user
	two_entry_buffer #(
		.W($bits(hbp_pkg::host_word_t))
	) u_wbuf (
		.clk_i(CORE_CLK_I),
		.resetn_i(RESETN_I),
		.in_valid_i(st.push),
		.in_data_i(st.word),
		.in_ready_o(in_ready),
		.out_valid_o(WR_VALID_O),
		.out_data_o(WR_WORD_O),
		.out_ready_i(WR_READY_I)
	);

	// Outputs straight from flops
	assign AD_O = st.ad_out;
	assign AD_OE_N_O = st.ad_oe_n;
	assign DRQ_O = st.drq;
	assign SERIAL_DO_O = st.sdo;
	assign RD_TAKEN_O = st.rd_taken;

endmodule

// ### include/hbp_cfg.svh
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH

// Port style encodings on the two-bit selector
`define STYLE_NONMUX 2'h0
`define STYLE_MUX 2'h1
`define STYLE_SERIAL 2'h2

// Clock rates in kHz
`define CORE_CLK_KHZ 100000
`define INT_CLK_KHZ 48000
// Memory clock is the internal clock divided by this
`define MCLK_DIV 4
// Core cycles per memory-clock period, rounded up (a least time)
`define MCLK_CYC ((`MCLK_DIV * `CORE_CLK_KHZ + `INT_CLK_KHZ - 1) / `INT_CLK_KHZ)
`define MCLK_CNT_W 4

// Recovery intervals in memory-clock periods
`define CPU_REC_MCLK 3
`define DMA_REC_MCLK 2
`define DMA_EXTRA_MCLK 2

// Serial group length and shift register reset value
`define SER_BITS 8
`define SHREG_RST 8'h00
`define AD_RST 8'h00

`endif

// ### include/hbp_pkg.sv
`include "hbp_cfg.svh"

package hbp_pkg;

	// One byte handed to the user side
	typedef struct packed {
		logic dma;
		logic addr;
		logic [7:0] data;
	} host_word_t;

	// Sampled host pins
	typedef struct packed {
		logic [1:0] style;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic a0;
		logic dack_n;
		logic sclk;
		logic sdi;
		logic [7:0] ad;
	} pin_t;

	// Access phase; idle to read, write to recover and recover to idle each change one bit
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_READ = 2'b01,
		PH_WRITE = 2'b11,
		PH_RECOVER = 2'b10
	} phase_t;

	// Whole state of the port
	typedef struct packed {
		pin_t s1;
		pin_t s2;
		pin_t s3;
		phase_t phase;
		logic [`MCLK_CNT_W-1:0] mdiv;
		logic [2:0] rec;
		logic dma_cyc;
		logic intr;
		logic addr;
		logic [7:0] ad_out;
		logic ad_oe_n;
		logic drq;
		logic rd_taken;
		logic push;
		host_word_t word;
		logic [7:0] shreg;
		logic [2:0] bitcnt;
		logic sdo;
	} port_state_t;

endpackage

// ### verilog/two_entry_buffer.sv
`timescale 1ns/1ps

module two_entry_buffer #(
	parameter int W = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);

	// Head feeds the output, spare catches a word during a stall
	typedef struct packed {
		logic hv;
		logic [W-1:0] head;
		logic sv;
		logic [W-1:0] spare;
	} buf_state_t;

	buf_state_t b;
	buf_state_t next_b;
	logic pop;
	logic push;

	// Ready is registered, so it never depends on the drain combinationally
	always_comb begin
		next_b = b;
		pop = b.hv & out_ready_i;
		push = in_valid_i & ~b.sv;
		if (pop || !b.hv) begin
			// Head slot is free this cycle
			if (b.sv) begin
				next_b.head = b.spare;
				next_b.hv = 1'b1;
				next_b.sv = push;
				next_b.spare = push ? in_data_i : b.spare;
			end else begin
				next_b.hv = push;
				next_b.head = push ? in_data_i : b.head;
			end
		end else if (push) begin
			// Head stalled, park the word
			next_b.sv = 1'b1;
			next_b.spare = in_data_i;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			b <= '0;
		end else begin
			b <= next_b;
		end
	end

	assign in_ready_o = ~b.sv;
	assign out_valid_o = b.hv;
	assign out_data_o = b.head;

endmodule

// ### dv/host_bus_port_asserts.sv
`timescale 1ns/1ps

module host_bus_port_chk (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// Host pins
	input wire logic CS_N_I,
	input wire logic RD_N_I,
	input wire logic WR_N_I,
	input wire logic DACK_N_I,
	input wire logic SERIAL_CLK_I,
	// User side
	input wire logic DMA_REQ_I,
	input wire logic WR_READY_I,
	// Watched outputs
	input wire logic AD_OE_N_O,
	input wire logic DRQ_O,
	input wire logic SERIAL_DO_O,
	input wire logic RD_TAKEN_O,
	input wire logic WR_VALID_O,
	input wire hbp_pkg::host_word_t WR_WORD_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);

	chk_reset_quiet: assert property (disable iff (1'b0)
		!RESETN_I |=> AD_OE_N_O && !DRQ_O && !WR_VALID_O && !RD_TAKEN_O)
		else $error("outputs not idle after reset");
	chk_drive_cause: assert property ($fell(AD_OE_N_O) |->
		!$past(RD_N_I, 2) && !$past(RD_N_I, 3))
		else $error("bus driven without a read strobe");
	chk_drive_release: assert property ($rose(RD_N_I) && !AD_OE_N_O |=>
		!AD_OE_N_O ##[1:4] AD_OE_N_O)
		else $error("bus release timing wrong");
	chk_taken_pulse: assert property ($rose(AD_OE_N_O) |->
		RD_TAKEN_O ##1 !RD_TAKEN_O)
		else $error("taken pulse missing or long");
	chk_drq_drop: assert property (($rose(RD_N_I) || $rose(WR_N_I)) &&
		!DACK_N_I && DRQ_O |-> ##[1:16] !DRQ_O)
		else $error("request not withdrawn in time");
	chk_drq_cause: assert property ($rose(DRQ_O) |-> $past(DMA_REQ_I))
		else $error("request raised without user demand");
	chk_dma_gap: assert property ($fell(DRQ_O) && $past(DMA_REQ_I) |->
		!DRQ_O [*8])
		else $error("request back before recovery");
	chk_serial_hold: assert property ($fell(SERIAL_CLK_I) && !CS_N_I |->
		##6 $stable(SERIAL_DO_O) [*8])
		else $error("serial output not settled");
	chk_word_hold: assert property (WR_VALID_O && !WR_READY_I |=>
		WR_VALID_O && $stable(WR_WORD_O))
		else $error("stalled word changed");
endmodule

bind host_bus_port host_bus_port_chk host_bus_port_chk_i (.CORE_CLK_I(CORE_CLK_I),
	.RESETN_I(RESETN_I), .CS_N_I(CS_N_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I),
	.DACK_N_I(DACK_N_I), .SERIAL_CLK_I(SERIAL_CLK_I), .DMA_REQ_I(DMA_REQ_I),
	.WR_READY_I(WR_READY_I), .AD_OE_N_O(AD_OE_N_O), .DRQ_O(DRQ_O),
	.SERIAL_DO_O(SERIAL_DO_O), .RD_TAKEN_O(RD_TAKEN_O), .WR_VALID_O(WR_VALID_O),
	.WR_WORD_O(WR_WORD_O));

// ### dv/host_cpu_model.sv
`timescale 1ns/1ps

module host_cpu_model (
	// Clock and device answers
	input wire logic clk_i,
	input wire logic drq_i,
	input wire logic sdo_i,
	input wire logic [7:0] ad_i,
	// Host pins; selects, strobes and serial clock idle high
	output logic cs_n_o = 1'b1,
	output logic rd_n_o = 1'b1,
	output logic wr_n_o = 1'b1,
	output logic ale_o = 1'b0,
	output logic a0_o = 1'b0,
	output logic dack_n_o = 1'b1,
	output logic sclk_o = 1'b1,
	output logic sdi_o = 1'b0,
	output logic [7:0] ad_o = 8'h00
);
	// One parallel or DMA access; m selects the latched style
	task automatic acc(input bit m, input bit w, input bit dma, input bit a,
		input logic [7:0] d, output logic [7:0] q);
		int i;
		repeat (4) @(posedge clk_i);
		for (i = 0; dma && !drq_i && i < 200; i++) @(posedge clk_i);
		cs_n_o <= dma;
		dack_n_o <= !dma;
		a0_o <= a;
		ale_o <= m;
		ad_o <= m ? {7'h00, a} : (w ? d : ~d);
		if (m) begin
			repeat (3) @(posedge clk_i);
			ale_o <= 1'b0;
			repeat (2) @(posedge clk_i);
			ad_o <= d;
		end
		rd_n_o <= w;
		wr_n_o <= !w;
		// strobe held past one internal clock, latched reads longer
		repeat ((m && !w) ? 30 : 5) @(posedge clk_i);
		q = ad_i;
		rd_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		dack_n_o <= 1'b1;
		ad_o <= ~ad_o;
		repeat (40) @(posedge clk_i);
	endtask

	// One serial group, MSB first, clock idles high
	task automatic ser(input logic [7:0] d, output logic [7:0] q);
		int i;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (i = 7; i >= 0; i--) begin
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			sdi_o <= d[i];
			repeat (40) @(posedge clk_i);
			q[i] = sdo_i;
			sclk_o <= 1'b1;
			repeat (36) @(posedge clk_i);
		end
		repeat (40) @(posedge clk_i);
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		repeat (40) @(posedge clk_i);
	endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] style = 2'h2;
	logic dma_req = 1'b0;
	logic [7:0] rd_data = 8'h96;
	logic wr_ready = 1'b0;
	logic cs_n, rd_n, wr_n, ale, a0, dack_n, sclk, sdi;
	logic ad_oe_n, drq, sdo, taken, wr_valid;
	logic [7:0] p_ad, ad_out, bus, q;
	hbp_pkg::host_word_t word;
	int errors = 0;
	int checks = 0;
	int taken_cnt = 0;

	// Count cycles with the taken pulse high; a long pulse counts more than once
	always @(posedge clk) begin
		if (taken === 1'b1) begin
			taken_cnt <= taken_cnt + 1;
		end
	end

	// Clock and the shared bus wire
	always #5 clk = ~clk;
	assign bus = ad_oe_n ? p_ad : ad_out;

	host_bus_port host_bus_port_i (.CORE_CLK_I(clk), .RESETN_I(rst_n),
		.PORT_STYLE_SEL_I(style), .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
		.ALE_I(ale), .A0_I(a0), .AD_I(bus), .AD_O(ad_out), .AD_OE_N_O(ad_oe_n),
		.DACK_N_I(dack_n), .DRQ_O(drq), .SERIAL_CLK_I(sclk), .SERIAL_DI_I(sdi),
		.SERIAL_DO_O(sdo), .DMA_REQ_I(dma_req), .RD_DATA_I(rd_data),
		.RD_TAKEN_O(taken), .WR_VALID_O(wr_valid), .WR_WORD_O(word),
		.WR_READY_I(wr_ready));

	host_cpu_model host_cpu_model_i (.clk_i(clk), .drq_i(drq), .sdo_i(sdo),
		.ad_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .ale_o(ale),
		.a0_o(a0), .dack_n_o(dack_n), .sclk_o(sclk), .sdi_o(sdi), .ad_o(p_ad));

	task cmp(input string n, input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Check the head word, then take it
	task pop(input logic [9:0] e);
		cmp("wr_valid", 10'h001, {9'h000, wr_valid});
		cmp("wr_word", e, word);
		@(posedge clk);
		wr_ready <= 1'b1;
		@(posedge clk);
		wr_ready <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task t_serial;
		host_cpu_model_i.ser(8'hc3, q);
		cmp("serial out", 10'h000, {2'h0, q});
		pop(10'h0c3);
		rd_data <= 8'h5a;
		host_cpu_model_i.ser(8'h3c, q);
		cmp("serial out", 10'h096, {2'h0, q});
		pop(10'h03c);
		cmp("taken count", 10'h002, 10'(taken_cnt));
	endtask

	task t_read;
		style <= 2'h0;
		rd_data <= 8'ha7;
		host_cpu_model_i.acc(0, 0, 0, 1, 8'h00, q);
		cmp("read data", 10'h0a7, {2'h0, q});
		rd_data <= 8'h18;
		host_cpu_model_i.acc(0, 0, 0, 0, 8'h00, q);
		cmp("read data", 10'h018, {2'h0, q});
		cmp("taken count", 10'h004, 10'(taken_cnt));
	endtask

	// Fill past the buffer while the user stalls
	task t_fill;
		host_cpu_model_i.acc(0, 1, 0, 1, 8'h11, q);
		host_cpu_model_i.acc(0, 1, 0, 0, 8'h22, q);
		host_cpu_model_i.acc(0, 1, 0, 1, 8'h33, q);
		pop(10'h111);
		pop(10'h022);
		pop(10'h133);
		cmp("wr_valid", 10'h000, {9'h000, wr_valid});
	endtask

	task t_mux;
		style <= 2'h1;
		rd_data <= 8'h6d;
		host_cpu_model_i.acc(1, 1, 0, 1, 8'he7, q);
		host_cpu_model_i.acc(1, 1, 0, 0, 8'h7e, q);
		host_cpu_model_i.acc(1, 0, 0, 1, 8'h00, q);
		cmp("mux read", 10'h06d, {2'h0, q});
		pop(10'h1e7);
		pop(10'h07e);
		// Unused style code ignores strobes entirely
		style <= 2'h3;
		host_cpu_model_i.acc(0, 1, 0, 0, 8'h55, q);
		cmp("wr_valid", 10'h000, {9'h000, wr_valid});
		cmp("taken count", 10'h005, 10'(taken_cnt));
	endtask

	task t_dma;
		style <= 2'h0;
		dma_req <= 1'b1;
		rd_data <= 8'h42;
		host_cpu_model_i.acc(0, 1, 1, 0, 8'h81, q);
		pop(10'h281);
		host_cpu_model_i.acc(0, 0, 1, 0, 8'h00, q);
		cmp("dma read", 10'h042, {2'h0, q});
		host_cpu_model_i.acc(0, 0, 0, 0, 8'h00, q);
		cmp("cpu read", 10'h042, {2'h0, q});
		host_cpu_model_i.acc(0, 1, 1, 0, 8'h99, q);
		pop(10'h299);
		dma_req <= 1'b0;
		repeat (3) @(posedge clk);
		cmp("drq", 10'h000, {9'h000, drq});
		cmp("taken count", 10'h007, 10'(taken_cnt));
	endtask

	task final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Reset, then the scenarios in order
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_serial;
		t_read;
		t_fill;
		t_mux;
		t_dma;
		final_report;
	end

	// Whole run needs about 2200 cycles
	initial begin
		repeat (10000) @(posedge clk);
		errors++;
		final_report;
	end
endmodule
